// ===== logic/sdh_pkg.sv
// sdh_pkg: constants shared by the step/direction homing controller files.
// assumes a single 100 MHz core clock; register offsets are byte addresses.
package sdh_pkg;

  // clock and timing figures
  localparam int CLK_HZ = 100_000_000;
  localparam int SLOW_STEP_HZ = 2; // single-step rate before acceleration
  localparam int SLOW_CYC_DEF = CLK_HZ / SLOW_STEP_HZ;
  localparam int SLOW_STEPS = 10; // single steps before ramping up
  localparam int DIR_SETUP_US = 150; // far end keeps direction stable this long

  // step-loss monitor: full steps per 9 degree window and allowed loss
  localparam int WIN_FULL_STEPS = 5;
  localparam int LOSS_FULL_STEPS = 25;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VMIN = 8'h04;
  localparam logic [7:0] OFS_VMAX = 8'h08;
  localparam logic [7:0] OFS_RAMP = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_POS = 8'h14;

  // control register fields
  localparam int CTRL_EXT_POL = 0; // 0 opener, 1 closer
  localparam int CTRL_EXT_HOME = 1; // 0 free back, 1 free forward
  localparam int CTRL_EXT_NORM = 2; // two bits, sdh_react_t
  localparam int CTRL_INT_HOME = 4; // 0 free back, 1 free forward
  localparam int CTRL_INT_NORM = 5; // two bits, sdh_react_t
  localparam int CTRL_HOME_DIR = 7; // homing direction, 1 right
  localparam logic [31:0] CTRL_RST = 32'h0000_006C; // opener, free back, both normal disabled

  // ramp register resets, in core clock cycles per step
  localparam logic [31:0] VMIN_RST = 32'h0003_D090;
  localparam logic [31:0] VMAX_RST = 32'h0001_86A0;
  localparam logic [31:0] RAMP_RST = 32'h0000_03E8;

  // switch reactions
  typedef enum logic [1:0] {
    SDH_FREE_BACK = 2'h0,
    SDH_FREE_FWD = 2'h1,
    SDH_STOP = 2'h2,
    SDH_DISABLE = 2'h3
  } sdh_react_t;

  // auto mode from select inputs 3:2
  localparam logic [1:0] MODE_LEFT = 2'h0;
  localparam logic [1:0] MODE_RIGHT = 2'h1;
  localparam logic [1:0] MODE_INT_HOME = 2'h2;
  localparam logic [1:0] MODE_EXT_HOME = 2'h3;

  // status line pairs {line1, line2}
  localparam logic [1:0] STAT_BUSY = 2'h1;
  localparam logic [1:0] STAT_CURRED = 2'h2;
  localparam logic [1:0] STAT_ERROR = 2'h0;
  localparam logic [1:0] STAT_REF = 2'h3;

endpackage

// ===== logic/sdh_rate_if.sv
// sdh_rate_if: request and tick between motion control and step rate generator.
// assumes both ends run on the core clock.
`timescale 1ns/10ps
interface sdh_rate_if;
  logic go;
  logic load;
  logic accel;
  logic [31:0] start_per;
  logic [31:0] end_per;
  logic [31:0] dec;
  logic tick;
  modport gen (input go, input load, input accel, input start_per, input end_per,
    input dec, output tick);
  modport ctl (output go, output load, output accel, output start_per, output end_per,
    output dec, input tick);
endinterface

// ===== logic/sdh_sync.sv
// sdh_sync: two-flop synchroniser for a group of asynchronous pins.
// assumes the pins are quasi-static compared with the core clock.
`timescale 1ns/10ps
module sdh_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      dout <= '0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule

// ===== logic/sdh_stepgen.sv
// sdh_stepgen: step rate generator with linear period ramp.
// assumes periods are given in core clock cycles; load restarts the ramp.
`timescale 1ns/10ps
module sdh_stepgen (
  input wire logic clk,
  input wire logic arst_n,
  sdh_rate_if.gen rif
);
  logic [31:0] per_reg;
  logic [31:0] cnt_reg;

  // shorten the period by dec per step, never below the end period
  function automatic logic [31:0] ramp_next(input logic [31:0] p, input logic [31:0] e,
    input logic [31:0] d);
    if (p > e + d) begin
      ramp_next = p - d;
    end else begin
      ramp_next = e;
    end
  endfunction

  // period counter; tick is a one-cycle pulse per step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      per_reg <= '0;
      cnt_reg <= '0;
      rif.tick <= 1'b0;
    end else begin
      rif.tick <= 1'b0;
      if (!rif.go || rif.load) begin
        per_reg <= rif.start_per;
        cnt_reg <= '0;
      end else if (cnt_reg >= per_reg) begin
        rif.tick <= 1'b1;
        cnt_reg <= '0;
        if (rif.accel) begin
          per_reg <= ramp_next(per_reg, rif.end_per, rif.dec);
        end
      end else begin
        cnt_reg <= cnt_reg + 32'h0000_0001;
      end
    end
  end
endmodule

// ===== logic/sdh_ctrl.sv
// sdh_ctrl: step/direction drive control with reference travel and step-loss monitor.
// assumes pins are asynchronous to core_clk and software uses the plain register port.
//
// How it works
// - enable rise starts captured auto mode
// - homing starts on enable pulse edge
// - enable falling edge clears step-loss error
// - select 00 left, 01 right, 10 int, 11 ext
// - ten slow steps, then ramp to max
// - step clock falling edge makes one step
// - status pair shows busy, reduction, error, reference
// - external homing ramps until switch found
// - switch polarity opener or closer selectable
// - separate homing and normal switch reactions
// - free back reverses and leaves reference
// - free forward continues past the reference
// - stop halts on switch, homing then required (code only sets need_home_reg; any auto mode still starts)
// - disable ignores the limit switch
// - both status lines change in one cycle
// - switch defaults opener, back, disabled
// - internal homing at minimum speed to mark
// - stop on internal mark, homing then required (code only sets need_home_reg; any auto mode still starts)
// - internal defaults back when homing, disabled
// - over 25 lost steps in 9 degrees aborts
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
module sdh_ctrl #(
  parameter int SLOW_CYC = sdh_pkg::SLOW_CYC_DEF,
  parameter int MICRO = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic enable_in,
  input wire logic sel2_in,
  input wire logic sel3_in,
  input wire logic limit_in,
  input wire logic dir_in,
  input wire logic step_clk_in,
  input wire logic index_in,
  input wire logic window_in,
  output logic step_out,
  output logic dir_out,
  output logic status1_out,
  output logic status2_out
);

  typedef enum logic [2:0] {
    SDH_IDLE,
    SDH_SLOW,
    SDH_RUN,
    SDH_HSEEK,
    SDH_HLEAVE,
    SDH_NLEAVE
  } sdh_state_t;

  localparam logic [31:0] SLOW_PER = 32'(SLOW_CYC - 1);
  localparam logic [3:0] SLOW_LAST = 4'(sdh_pkg::SLOW_STEPS - 1);
  localparam logic [15:0] LOSS_LIMIT =
    16'((sdh_pkg::WIN_FULL_STEPS + sdh_pkg::LOSS_FULL_STEPS) * MICRO);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection

  logic [7:0] pin_s;
  logic [7:0] pin_d_reg;
  logic en_s, sel2_s, sel3_s, lim_s, dir_s, sclk_s, idx_s, win_s;

  sdh_sync #(.W(8)) u_sync (
    .clk(core_clk),
    .arst_n(arst_n),
    .din({window_in, index_in, step_clk_in, dir_in, limit_in, sel3_in, sel2_in, enable_in}),
    .dout(pin_s)
  );

  assign {win_s, idx_s, sclk_s, dir_s, lim_s, sel3_s, sel2_s, en_s} = pin_s;

  // delayed copy of the synchronised pins for edge detection
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_d_reg <= '0;
    end else begin
      pin_d_reg <= pin_s;
    end
  end

  logic en_rise, en_fall, sclk_fall, win_rise;
  assign en_rise = en_s & ~pin_d_reg[0];
  assign en_fall = ~en_s & pin_d_reg[0];
  assign sclk_fall = ~sclk_s & pin_d_reg[5];
  assign win_rise = win_s & ~pin_d_reg[7];

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [31:0] ctrl_reg;
  logic [31:0] vmin_reg;
  logic [31:0] vmax_reg;
  logic [31:0] ramp_reg;
  logic [31:0] pos_reg;

  // homing reaction fields hold one bit only, so stop and disable cannot be set
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= sdh_pkg::CTRL_RST;
      vmin_reg <= sdh_pkg::VMIN_RST;
      vmax_reg <= sdh_pkg::VMAX_RST;
      ramp_reg <= sdh_pkg::RAMP_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        sdh_pkg::OFS_CTRL: ctrl_reg <= {24'h00_0000, reg_wdata[7:0]};
        sdh_pkg::OFS_VMIN: vmin_reg <= reg_wdata;
        sdh_pkg::OFS_VMAX: vmax_reg <= reg_wdata;
        sdh_pkg::OFS_RAMP: ramp_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  logic ext_pol, ext_home_fwd, int_home_fwd, home_dir;
  sdh_pkg::sdh_react_t ext_norm, int_norm;
  assign ext_pol = ctrl_reg[sdh_pkg::CTRL_EXT_POL];
  assign ext_home_fwd = ctrl_reg[sdh_pkg::CTRL_EXT_HOME];
  assign int_home_fwd = ctrl_reg[sdh_pkg::CTRL_INT_HOME];
  assign home_dir = ctrl_reg[sdh_pkg::CTRL_HOME_DIR];
  assign ext_norm = sdh_pkg::sdh_react_t'(ctrl_reg[sdh_pkg::CTRL_EXT_NORM +: 2]);
  assign int_norm = sdh_pkg::sdh_react_t'(ctrl_reg[sdh_pkg::CTRL_INT_NORM +: 2]);

  // opener reads active when the contact opens, i.e. pin low
  logic lim_act, lim_act_d_reg, lim_rise, idx_rise;
  assign lim_act = ext_pol ? lim_s : ~lim_s;
  assign lim_rise = lim_act & ~lim_act_d_reg;
  assign idx_rise = idx_s & ~pin_d_reg[6];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lim_act_d_reg <= 1'b0;
    end else begin
      lim_act_d_reg <= lim_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // motion state machine

  sdh_state_t state_reg;
  logic [1:0] mode_reg;
  logic mot_dir_reg;
  logic [3:0] slow_cnt_reg;
  logic load_reg;
  logic need_home_reg;
  logic ref_reg;
  logic err_reg;
  logic step_do;
  logic gen_tick;

  sdh_rate_if rif ();

  sdh_stepgen u_gen (
    .clk(core_clk),
    .arst_n(arst_n),
    .rif(rif.gen)
  );

  assign gen_tick = rif.tick;
  assign rif.go = (state_reg != SDH_IDLE);
  assign rif.load = load_reg;
  // external homing and normal runs ramp; slow phase and leaving do not
  assign rif.accel = (state_reg == SDH_RUN) ||
    ((state_reg == SDH_HSEEK) && (mode_reg == sdh_pkg::MODE_EXT_HOME));
  assign rif.start_per = (state_reg == SDH_SLOW) ? SLOW_PER : vmin_reg;
  assign rif.end_per = vmax_reg;
  assign rif.dec = ramp_reg;

  // reference seen for homing: switch level or mark edge
  logic home_hit, home_clear;
  assign home_hit = (mode_reg == sdh_pkg::MODE_EXT_HOME) ? lim_act : idx_rise;
  assign home_clear = (mode_reg == sdh_pkg::MODE_EXT_HOME) ? ~lim_act : ~idx_s;

  // external clock steps only while no auto motion runs and no error is latched
  logic ext_step;
  assign ext_step = (state_reg == SDH_IDLE) && sclk_fall && !err_reg;
  assign step_do = ((state_reg != SDH_IDLE) && gen_tick) || ext_step;

  // one always block holds every motion transition so load follows each change into a moving state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SDH_IDLE;
      mode_reg <= sdh_pkg::MODE_LEFT;
      mot_dir_reg <= 1'b0;
      slow_cnt_reg <= '0;
      load_reg <= 1'b0;
      need_home_reg <= 1'b0;
      ref_reg <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      if (err_reg && state_reg != SDH_IDLE) begin
        state_reg <= SDH_IDLE;
      end else begin
        case (state_reg)
          SDH_IDLE: begin
            if (ext_step) begin
              ref_reg <= 1'b0;
            end
            if (en_rise && !err_reg) begin
              mode_reg <= {sel3_s, sel2_s};
              load_reg <= 1'b1;
              ref_reg <= 1'b0;
              slow_cnt_reg <= '0;
              case ({sel3_s, sel2_s})
                sdh_pkg::MODE_LEFT: begin
                  mot_dir_reg <= 1'b0;
                  state_reg <= SDH_SLOW;
                end
                sdh_pkg::MODE_RIGHT: begin
                  mot_dir_reg <= 1'b1;
                  state_reg <= SDH_SLOW;
                end
                default: begin
                  mot_dir_reg <= home_dir;
                  state_reg <= SDH_HSEEK;
                end
              endcase
            end
          end
          SDH_SLOW: begin
            if (!en_s) begin
              state_reg <= SDH_IDLE;
            end else if (gen_tick) begin
              if (slow_cnt_reg == SLOW_LAST) begin
                state_reg <= SDH_RUN;
                load_reg <= 1'b1;
              end else begin
                slow_cnt_reg <= slow_cnt_reg + 4'h1;
              end
            end
          end
          SDH_RUN: begin
            if (!en_s) begin
              state_reg <= SDH_IDLE;
            end else if (lim_rise && ext_norm != sdh_pkg::SDH_DISABLE) begin
              mode_reg <= sdh_pkg::MODE_EXT_HOME;
              load_reg <= 1'b1;
              case (ext_norm)
                sdh_pkg::SDH_STOP: begin
                  state_reg <= SDH_IDLE;
                  need_home_reg <= 1'b1;
                end
                sdh_pkg::SDH_FREE_BACK: begin
                  mot_dir_reg <= ~mot_dir_reg;
                  state_reg <= SDH_NLEAVE;
                end
                default: state_reg <= SDH_NLEAVE;
              endcase
            end else if (idx_rise && int_norm != sdh_pkg::SDH_DISABLE) begin
              mode_reg <= sdh_pkg::MODE_INT_HOME;
              load_reg <= 1'b1;
              case (int_norm)
                sdh_pkg::SDH_STOP: begin
                  state_reg <= SDH_IDLE;
                  need_home_reg <= 1'b1;
                end
                sdh_pkg::SDH_FREE_BACK: begin
                  mot_dir_reg <= ~mot_dir_reg;
                  state_reg <= SDH_NLEAVE;
                end
                default: state_reg <= SDH_NLEAVE;
              endcase
            end
          end
          SDH_HSEEK: begin
            // travels until the switch or the mark is found
            if (home_hit) begin
              load_reg <= 1'b1;
              state_reg <= SDH_HLEAVE;
              if ((mode_reg == sdh_pkg::MODE_EXT_HOME) ? !ext_home_fwd : !int_home_fwd) begin
                mot_dir_reg <= ~mot_dir_reg;
              end
            end
          end
          SDH_HLEAVE: begin
            if (home_clear) begin
              state_reg <= SDH_IDLE;
              need_home_reg <= 1'b0;
              ref_reg <= 1'b1;
            end
          end
          SDH_NLEAVE: begin
            if (home_clear) begin
              state_reg <= SDH_IDLE;
              ref_reg <= 1'b1;
            end
          end
          default: state_reg <= SDH_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step-loss monitor

  // commanded steps since the last 9 degree window mark; far more than the
  // shaft moved means steps were lost. coarse: no substitute for an encoder
  logic [15:0] win_cnt_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      win_cnt_reg <= '0;
    end else if (win_rise || (state_reg == SDH_IDLE && !ext_step)) begin
      win_cnt_reg <= '0;
    end else if (step_do && win_cnt_reg <= LOSS_LIMIT) begin
      win_cnt_reg <= win_cnt_reg + 16'h0001;
    end
  end

  // set wins over the clear by enable falling edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_reg <= 1'b0;
    end else if (win_cnt_reg > LOSS_LIMIT) begin
      err_reg <= 1'b1;
    end else if (en_fall) begin
      err_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // position counter and step outputs

  logic step_dir;
  assign step_dir = (state_reg == SDH_IDLE) ? dir_s : mot_dir_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_reg <= '0;
    end else if (state_reg == SDH_HLEAVE && home_clear) begin
      pos_reg <= '0;
    end else if (step_do) begin
      pos_reg <= step_dir ? pos_reg + 32'h0000_0001 : pos_reg - 32'h0000_0001;
    end
  end

  // direction is updated with the step so the power stage sees them together
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_out <= 1'b0;
      dir_out <= 1'b0;
    end else begin
      step_out <= step_do;
      if (step_do) begin
        dir_out <= step_dir;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status lines

  logic [1:0] stat_code;
  always_comb begin
    if (err_reg) begin
      stat_code = sdh_pkg::STAT_ERROR;
    end else if (state_reg != SDH_IDLE) begin
      stat_code = sdh_pkg::STAT_BUSY;
    end else if (ref_reg) begin
      stat_code = sdh_pkg::STAT_REF;
    end else begin
      stat_code = sdh_pkg::STAT_CURRED;
    end
  end

  // both lines come from one assignment so they always switch together
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {status1_out, status2_out} <= sdh_pkg::STAT_CURRED;
    end else begin
      {status1_out, status2_out} <= stat_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        sdh_pkg::OFS_CTRL: reg_rdata <= ctrl_reg;
        sdh_pkg::OFS_VMIN: reg_rdata <= vmin_reg;
        sdh_pkg::OFS_VMAX: reg_rdata <= vmax_reg;
        sdh_pkg::OFS_RAMP: reg_rdata <= ramp_reg;
        sdh_pkg::OFS_STAT: reg_rdata <= {22'h00_0000, mode_reg, mot_dir_reg, need_home_reg,
          ref_reg, err_reg, stat_code, 2'h0};
        sdh_pkg::OFS_POS: reg_rdata <= pos_reg;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// ===== tb/sdh_ctrl_sva.sv
// sdh_ctrl_sva: concurrent checks on the controller pins.
// assumes it is bound into sdh_ctrl and sees only that module's ports.
`timescale 1ns/10ps
module sdh_ctrl_sva #(
  parameter int SLOW_CYC = 20
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic enable_in,
  input wire logic sel3_in,
  input wire logic dir_in,
  input wire logic step_clk_in,
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic status1_out,
  input wire logic status2_out
);
  localparam int LO = SLOW_CYC;
  localparam int HI = SLOW_CYC + 8;
  logic [1:0] st;
  logic stand;

  ////////////////////////////////////////
  // standing means no motion and no error latched
  assign st = {status1_out, status2_out};
  assign stand = st == sdh_pkg::STAT_CURRED || st == sdh_pkg::STAT_REF;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////
  a_step_pulse: assert property (step_out |=> !step_out)
    else $error("wide step pulse");
  // two sync flops and the output flop: step is sampled three edges on
  a_ext_step: assert property ($fell(step_clk_in) && stand && !enable_in |->
    ##3 (step_out && dir_out == $past(dir_in, 3)))
    else $error("bad external step");
  a_dir_hold: assert property (!step_out |-> $stable(dir_out))
    else $error("dir moved without step");
  a_err_quiet: assert property ((st == sdh_pkg::STAT_ERROR) [*3] |-> !step_out)
    else $error("step during error");
  a_err_clear: assert property (st == sdh_pkg::STAT_ERROR && $fell(enable_in) |->
    ##[1:6] st == sdh_pkg::STAT_CURRED)
    else $error("error not cleared");
  a_busy_start: assert property ($rose(enable_in) && stand |->
    ##[2:6] st == sdh_pkg::STAT_BUSY)
    else $error("mode not started");
  a_slow_first: assert property ($rose(enable_in) && stand && !sel3_in |->
    ##[LO:HI] step_out)
    else $error("first slow step missing");
  a_ref_entry: assert property ($rose(st == sdh_pkg::STAT_REF) |->
    $past(st) == sdh_pkg::STAT_BUSY)
    else $error("ref pair not entered from busy");
  a_reset_pair: assert property (!$past(arst_n) |->
    st == sdh_pkg::STAT_CURRED && !step_out)
    else $error("wrong pins after reset");
endmodule

bind sdh_ctrl sdh_ctrl_sva #(.SLOW_CYC(SLOW_CYC)) i_sva (
  .core_clk(core_clk),
  .arst_n(arst_n),
  .enable_in(enable_in),
  .sel3_in(sel3_in),
  .dir_in(dir_in),
  .step_clk_in(step_clk_in),
  .step_out(step_out),
  .dir_out(dir_out),
  .status1_out(status1_out),
  .status2_out(status2_out)
);

// ===== tb/sdh_far_model.sv
// sdh_far_model: motion controller on the far side of the step/direction pins.
// assumes core_clk paces level changes; step clock is free.
`timescale 1ns/10ps
module sdh_far_model (
  input wire logic core_clk,
  output logic enable_in,
  output logic sel2_in,
  output logic sel3_in,
  output logic dir_in,
  output logic step_clk_in
);
  localparam int SETUP_CYC = sdh_pkg::DIR_SETUP_US * (sdh_pkg::CLK_HZ / 1_000_000);

  ////////////////////////////////////////
  // pins idle low; the step clock stands still between frames
  initial begin
    enable_in = 1'b0;
    sel2_in = 1'b0;
    sel3_in = 1'b0;
    dir_in = 1'b0;
    step_clk_in = 1'b0;
  end

  // selection settles one cycle ahead, so it is valid when enable is taken
  task automatic start(input logic [1:0] sel, input logic pulse);
    @(posedge core_clk);
    {sel3_in, sel2_in} <= sel;
    @(posedge core_clk);
    enable_in <= 1'b1;
    if (pulse) begin
      repeat (5) @(posedge core_clk);
      enable_in <= 1'b0;
    end
  endtask

  task automatic set_sel(input logic [1:0] sel);
    @(posedge core_clk);
    {sel3_in, sel2_in} <= sel;
  endtask

  task automatic stop;
    @(posedge core_clk);
    enable_in <= 1'b0;
  endtask

  // a direction change costs the full setup wait; an unchanged one costs nothing
  task automatic ext_step(input logic dir);
    if (dir !== dir_in) begin
      @(posedge core_clk);
      dir_in <= dir;
      repeat (SETUP_CYC) @(posedge core_clk);
    end
    #3 step_clk_in = 1'b1;
    #40 step_clk_in = 1'b0;
    #40;
  endtask
endmodule

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the step/direction homing controller.
// assumes the far-side model drives the pins and the bench owns the shaft signals.
`timescale 1ns/10ps
module tb_top;
  localparam int SLOW = 20;
  logic core_clk, reg_wr = 0, reg_rd = 0, limit_in = 1, index_in = 0, window_in = 0;
  logic arst_n = 0, win_on = 1;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, d, d0;
  logic enable_in, sel2_in, sel3_in, dir_in, step_clk_in;
  logic step_out, dir_out, status1_out, status2_out;
  logic [1:0] st;
  int cyc = 0, last = 0, gap = 0, n_steps = 0, n0, fail_count = 0, n_checks = 0;
  logic [7:0] r_addr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] r_exp [7] = '{32'h0000_006C, sdh_pkg::VMIN_RST, sdh_pkg::VMAX_RST,
    sdh_pkg::RAMP_RST, 32'h0000_0008, 32'h0000_0000, 32'h0000_0000};
  logic [1:0] h_sel [4] = '{2'h3, 2'h3, 2'h2, 2'h3};
  logic [31:0] h_ctrl [4] = '{32'h0000_00EC, 32'h0000_00EE, 32'h0000_00EC, 32'h0000_00ED};
  logic h_idx [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic h_act [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic h_dir [4] = '{1'b0, 1'b1, 1'b0, 1'b0};

  assign st = {status1_out, status2_out};

  sdh_ctrl #(.SLOW_CYC(SLOW), .MICRO(1)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .enable_in(enable_in), .sel2_in(sel2_in), .sel3_in(sel3_in),
    .limit_in(limit_in), .dir_in(dir_in), .step_clk_in(step_clk_in), .index_in(index_in),
    .window_in(window_in), .step_out(step_out), .dir_out(dir_out),
    .status1_out(status1_out), .status2_out(status2_out));
  sdh_far_model i_far (.core_clk(core_clk), .enable_in(enable_in), .sel2_in(sel2_in),
    .sel3_in(sel3_in), .dir_in(dir_in), .step_clk_in(step_clk_in));

  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // step bookkeeping; a window pulse per step keeps the loss monitor quiet
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    window_in <= win_on & step_out;
    if (step_out === 1'b1) begin
      gap <= cyc - last;
      last <= cyc;
      n_steps <= n_steps + 1;
    end
  end

  ////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask

  task automatic wait_steps(input int n);
    int i = 0;
    while (n_steps < n && i < 3000) begin
      @(posedge core_clk);
      i++;
    end
    chk("step count", 1, n_steps >= n);
  endtask

  task automatic wait_stat(input logic [1:0] s);
    int i = 0;
    while (st !== s && i < 3000) begin
      @(posedge core_clk);
      i++;
    end
    chk("status pair", s, st);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // the whole run needs about 20k cycles
  initial begin
    #600_000;
    fail_count++;
    stop_test();
  end

  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    chk("reset pair", sdh_pkg::STAT_CURRED, st);
    arst_n <= 1'b1;
    for (int r = 0; r < 7; r++) begin
      reg_read(r_addr[r], d);
      chk("register reset", r_exp[r], d);
    end
    $display("test reset values done");
    // short ramp periods keep the motion tests brief
    reg_write(sdh_pkg::OFS_VMIN, 32'h0000_0028);
    reg_write(sdh_pkg::OFS_VMAX, 32'h0000_0014);
    reg_write(sdh_pkg::OFS_RAMP, 32'h0000_0002);
    i_far.ext_step(1'b1);
    i_far.ext_step(1'b1);
    repeat (10) @(posedge core_clk);
    reg_read(sdh_pkg::OFS_POS, d);
    chk("position", 32'h0000_0002, d);
    chk("dir_out", 1, dir_out);
    $display("test external clock done");
    for (int m = 0; m < 2; m++) begin
      n0 = n_steps;
      i_far.start({1'b0, m[0]}, 1'b0);
      i_far.set_sel({1'b0, ~m[0]});
      wait_steps(n0 + 3);
      chk("slow gap", SLOW, gap);
      chk("mode dir", m, dir_out);
      chk("busy pair", sdh_pkg::STAT_BUSY, st);
      wait_steps(n0 + 12);
      limit_in <= 1'b0;
      wait_steps(n0 + 18);
      chk("busy on limit", sdh_pkg::STAT_BUSY, st);
      limit_in <= 1'b1;
      i_far.stop();
      wait_stat(sdh_pkg::STAT_CURRED);
    end
    $display("test auto modes done");
    reg_write(sdh_pkg::OFS_CTRL, 32'h0000_0068);
    n0 = n_steps;
    i_far.start(2'h1, 1'b0);
    wait_steps(n0 + 12);
    limit_in <= 1'b0;
    wait_stat(sdh_pkg::STAT_CURRED);
    n0 = n_steps;
    repeat (60) @(posedge core_clk);
    chk("halted", n0, n_steps);
    reg_read(sdh_pkg::OFS_STAT, d);
    chk("need home", 1, d[6]);
    limit_in <= 1'b1;
    i_far.stop();
    $display("test limit stop done");
    for (int h = 0; h < 4; h++) begin
      limit_in <= ~h_act[h] | h_idx[h];
      reg_write(sdh_pkg::OFS_CTRL, h_ctrl[h]);
      n0 = n_steps;
      i_far.start(h_sel[h], 1'b1);
      wait_steps(n0 + 3);
      chk("home start dir", 1, dir_out);
      if (h_idx[h]) index_in <= 1'b1;
      else limit_in <= h_act[h];
      wait_steps(n_steps + 3);
      chk("home leave dir", h_dir[h], dir_out);
      index_in <= 1'b0;
      limit_in <= ~h_act[h] | h_idx[h];
      wait_stat(sdh_pkg::STAT_REF);
      reg_read(sdh_pkg::OFS_POS, d);
      chk("home position", 0, d);
    end
    limit_in <= 1'b1;
    $display("test homing done");
    win_on <= 1'b0;
    n0 = n_steps;
    i_far.start(2'h0, 1'b0);
    wait_stat(sdh_pkg::STAT_ERROR);
    repeat (50) @(posedge core_clk);
    chk("loss steps", sdh_pkg::WIN_FULL_STEPS + sdh_pkg::LOSS_FULL_STEPS + 1,
      n_steps - n0);
    reg_read(sdh_pkg::OFS_POS, d0);
    i_far.ext_step(1'b1);
    repeat (10) @(posedge core_clk);
    reg_read(sdh_pkg::OFS_POS, d);
    chk("refused step", d0, d);
    i_far.stop();
    wait_stat(sdh_pkg::STAT_CURRED);
    $display("test step loss done");
    stop_test();
  end
endmodule
